// ===== verilog/prc_defines.svh
// Named constants for the presettable ripple counter and latch
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PRC_CLK_PERIOD_NS 40
`define PRC_ENABLE_TIME_NS 25
// Least time rounds up to whole cycles
`define PRC_ENABLE_CYCLES_RAW \
    ((`PRC_ENABLE_TIME_NS + `PRC_CLK_PERIOD_NS - 1) / `PRC_CLK_PERIOD_NS)
`define PRC_ENABLE_CYCLES ((`PRC_ENABLE_CYCLES_RAW < 1) ? 1 : `PRC_ENABLE_CYCLES_RAW)
`define PRC_EN_CNT_W 4

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define PRC_BIT_LOW 1'h0
`define PRC_BIT_HIGH 1'h1
`define PRC_UPPER_ZERO 3'h0
`define PRC_UPPER_ONE 3'h1
`define PRC_DIV5_LAST 3'h4
`define PRC_DATA_ZERO 4'h0
`define PRC_DATA_W 4
`define PRC_PIN_W 8

// ----------------------------------------------------------------------
// Field positions in the synchronised pin bundle
// ----------------------------------------------------------------------
`define PRC_PIN_DATA_LSB 0
`define PRC_PIN_DATA_MSB 3
`define PRC_PIN_CLEAR 4
`define PRC_PIN_PRESET 5
`define PRC_PIN_UPPER 6
`define PRC_PIN_FIRST 7

`endif

// ===== verilog/prc_pkg.sv
// Types shared by the presettable ripple counter files
package prc_pkg;

    // ------------------------------------------------------------------
    // Pin bundle, one bit per asynchronous input
    // ------------------------------------------------------------------
    typedef struct packed {
        logic first_count;
        logic upper_count;
        logic preset_sel_n;
        logic clear_n;
        logic [3:0] data;
    } prc_pins_t;

    // ------------------------------------------------------------------
    // State of one synchroniser bit
    // ------------------------------------------------------------------
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
    } prc_sync_t;

    // ------------------------------------------------------------------
    // State of the counter core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic first_prev;
        logic upper_prev;
        logic [3:0] en_cnt;
        logic stage0;
        logic [2:0] upper;
    } prc_state_t;

endpackage

// ===== verilog/prc_sync.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_sync #(
    parameter logic RST_VAL = 1'h0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic level
);

    prc_pkg::prc_sync_t st_q;
    prc_pkg::prc_sync_t st_d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // First flop feeds only the second; level moves when second and third agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.stable = st_q.s3;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset to the inactive level so no false edge or load appears
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.stable;

endmodule

// ===== verilog/prc_counter.sv
// Presettable ripple counter and latch, decade or binary variant
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_counter #(
    parameter bit DECADE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic first_count_in,
    input wire logic upper_section_count_in,
    input wire logic preset_sel_n,
    input wire logic clear_n,
    input wire logic [3:0] data_in,
    output logic stage0_output,
    output logic stage1_output,
    output logic stage2_output,
    output logic stage3_output
);

    // ------------------------------------------------------------------
    // Enable window as a cycle count
    // ------------------------------------------------------------------
    // A single cycle at 25 MHz already covers the 25 ns window
    localparam logic [3:0] EN_CYCLES = 4'(`PRC_ENABLE_CYCLES);

    // ------------------------------------------------------------------
    // Upper section next value
    // ------------------------------------------------------------------
    // Decade wraps after four; preset values five to seven also return to zero,
    // which keeps a stray load from locking the section out of its cycle
    function automatic logic [2:0] prc_upper_next(input logic [2:0] v);
        logic [2:0] nxt;
        nxt = 3'(v + `PRC_UPPER_ONE);
        if (DECADE && (v >= `PRC_DIV5_LAST)) begin
            nxt = `PRC_UPPER_ZERO;
        end
        return nxt;
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    prc_pkg::prc_pins_t pins_raw;
    prc_pkg::prc_pins_t pins;
    logic [`PRC_PIN_W-1:0] pins_vec;

    // Bundle the pins in a fixed order
    always_comb begin
        pins_raw.first_count = first_count_in;
        pins_raw.upper_count = upper_section_count_in;
        pins_raw.preset_sel_n = preset_sel_n;
        pins_raw.clear_n = clear_n;
        pins_raw.data = data_in;
    end

    // First count resets low, so its rise after reset is not a falling edge
    prc_sync #(
        .RST_VAL(`PRC_BIT_LOW)
    ) u_sync_first (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.first_count),
        .level(pins_vec[`PRC_PIN_FIRST])
    );

    // Upper count resets low for the same reason
    prc_sync #(
        .RST_VAL(`PRC_BIT_LOW)
    ) u_sync_upper (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.upper_count),
        .level(pins_vec[`PRC_PIN_UPPER])
    );

    // Preset-select resets inactive high, so release loads nothing
    prc_sync #(
        .RST_VAL(`PRC_BIT_HIGH)
    ) u_sync_preset (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.preset_sel_n),
        .level(pins_vec[`PRC_PIN_PRESET])
    );

    // Clear resets inactive high, so release clears nothing
    prc_sync #(
        .RST_VAL(`PRC_BIT_HIGH)
    ) u_sync_clear (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.clear_n),
        .level(pins_vec[`PRC_PIN_CLEAR])
    );

    // Data bit for stage 0
    prc_sync #(
        .RST_VAL(`PRC_BIT_LOW)
    ) u_sync_data0 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.data[0]),
        .level(pins_vec[`PRC_PIN_DATA_LSB])
    );

    // Data bit for stage 1
    prc_sync #(
        .RST_VAL(`PRC_BIT_LOW)
    ) u_sync_data1 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.data[1]),
        .level(pins_vec[`PRC_PIN_DATA_LSB + 1])
    );

    // Data bit for stage 2
    prc_sync #(
        .RST_VAL(`PRC_BIT_LOW)
    ) u_sync_data2 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.data[2]),
        .level(pins_vec[`PRC_PIN_DATA_LSB + 2])
    );

    // Data bit for stage 3; all filters share one latency, so data and load stay aligned
    prc_sync #(
        .RST_VAL(`PRC_BIT_LOW)
    ) u_sync_data3 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(pins_raw.data[3]),
        .level(pins_vec[`PRC_PIN_DATA_MSB])
    );

    // Packed view of the filtered pins
    assign pins = pins_vec;

    // ------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------
    prc_pkg::prc_state_t st_q;
    prc_pkg::prc_state_t st_d;
    logic first_fall;
    logic upper_fall;
    logic count_ok;
    logic ctrl_high;

    // Falling edges of the filtered count inputs
    always_comb begin
        first_fall = st_q.first_prev && !pins.first_count;
        upper_fall = st_q.upper_prev && !pins.upper_count;
    end

    // Both controls high, and held so for the window before this edge
    always_comb begin
        ctrl_high = pins.preset_sel_n && pins.clear_n;
        count_ok = ctrl_high && (st_q.en_cnt >= EN_CYCLES);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Clear, then load, then counting; priority settles the overlap case
    always_comb begin
        st_d = st_q;
        st_d.first_prev = pins.first_count;
        st_d.upper_prev = pins.upper_count;
        // Saturating count of cycles with both controls high
        if (!ctrl_high) begin
            st_d.en_cnt = '0;
        end else if (st_q.en_cnt < EN_CYCLES) begin
            st_d.en_cnt = 4'(st_q.en_cnt + 4'h1);
        end
        if (!pins.clear_n) begin
            // Clear wins over load and over any edge
            st_d.stage0 = `PRC_BIT_LOW;
            st_d.upper = `PRC_UPPER_ZERO;
        end else if (!pins.preset_sel_n) begin
            // Transparent latch while preset-select is low
            st_d.stage0 = pins.data[0];
            st_d.upper = pins.data[3:1];
        end else begin
            // Stage 0 sees only the first count input; no internal chain
            if (first_fall && count_ok) begin
                st_d.stage0 = !st_q.stage0;
            end
            // Upper section sees only its own input; wiring is external
            if (upper_fall && count_ok) begin
                st_d.upper = prc_upper_next(st_q.upper);
            end
            // With no edge, last loaded or counted value holds
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q <= '{
                first_prev: `PRC_BIT_LOW,
                upper_prev: `PRC_BIT_LOW,
                en_cnt: 4'h0,
                stage0: `PRC_BIT_LOW,
                upper: `PRC_UPPER_ZERO
            };
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // All straight from flops, so external feedback wiring sees clean levels
    // Wiring stage 0 or stage 3 back to a count input builds the chained modes
    assign stage0_output = st_q.stage0;
    assign stage1_output = st_q.upper[0];
    assign stage2_output = st_q.upper[1];
    assign stage3_output = st_q.upper[2];

endmodule

// ===== verif/prc_counter_sva.sv
// Port assertions for the presettable ripple counter
`timescale 1ns/1ps
module prc_counter_sva #(
    parameter bit DECADE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic first_count_in,
    input wire logic upper_section_count_in,
    input wire logic preset_sel_n,
    input wire logic clear_n,
    input wire logic [3:0] data_in,
    input wire logic stage0_output,
    input wire logic stage1_output,
    input wire logic stage2_output,
    input wire logic stage3_output
);
    // ------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------
    logic [2:0] up_s;
    logic [3:0] q_s;
    logic ctl_s;
    assign up_s = {stage3_output, stage2_output, stage1_output};
    assign q_s = {up_s, stage0_output};
    assign ctl_s = clear_n && preset_sel_n;

    // Decade section returns to zero after four, even from a loaded 5..7
    function automatic logic [2:0] up_next(input logic [2:0] u);
        if (DECADE && u >= 3'h4) begin
            return 3'h0;
        end
        return u + 3'h1;
    endfunction

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    clear_low_a: assert property (!clear_n [*6] |-> q_s == 4'h0)
        else $error("outputs not cleared");
    load_follow_a: assert property ((clear_n && !preset_sel_n && $stable(data_in)) [*6]
        |-> q_s == data_in)
        else $error("outputs do not follow data");
    clear_wins_a: assert property ((!clear_n && !preset_sel_n) [*6] |-> q_s == 4'h0)
        else $error("clear lost to load");
    stage0_hold_a: assert property ((ctl_s && $stable(first_count_in)) [*6]
        |=> $stable(stage0_output))
        else $error("stage 0 moved without its edge");
    upper_hold_a: assert property ((ctl_s && $stable(upper_section_count_in)) [*6]
        |=> $stable(up_s))
        else $error("upper section moved without its edge");
    stage0_step_a: assert property ((ctl_s [*4] ##0 $fell(first_count_in)) ##1 ctl_s [*4]
        |=> stage0_output != $past(stage0_output))
        else $error("stage 0 missed a counted edge");
    upper_step_a: assert property ((ctl_s [*4] ##0 $fell(upper_section_count_in))
        ##1 ctl_s [*4] |=> up_s == up_next($past(up_s)))
        else $error("upper section stepped wrongly");
    load_keep_a: assert property ((!preset_sel_n && clear_n && $stable(data_in)) [*6] ##1
        (ctl_s && $stable(first_count_in) && $stable(upper_section_count_in)) [*6]
        |-> q_s == $past(data_in, 6))
        else $error("loaded value not kept");

    cover property ($fell(upper_section_count_in) && ctl_s);
    cover property (!clear_n [*6]);
    cover property (!preset_sel_n [*6]);
endmodule

bind prc_counter prc_counter_sva #(.DECADE(DECADE)) i_sva (.core_clk, .rst_b,
    .first_count_in, .upper_section_count_in, .preset_sel_n, .clear_n, .data_in,
    .stage0_output, .stage1_output, .stage2_output, .stage3_output);

// ===== verif/prc_src.sv
// Count pulse source and external feedback wiring for two counters
`timescale 1ns/1ps
module prc_src (
    input wire logic core_clk,
    input wire logic [1:0] fb_mode,
    input wire logic s0_a,
    input wire logic s3_a,
    input wire logic s0_b,
    input wire logic s3_b,
    output logic first_a,
    output logic upper_a,
    output logic first_b,
    output logic upper_b
);
    // Count lines idle high, so only a pulse gives a falling edge
    logic raw_first = 1'h1;
    logic raw_upper = 1'h1;

    // Mode 1 chains stage 0 to the upper input, mode 2 stage 3 to the first
    assign first_a = (fb_mode == 2'h2) ? s3_a : raw_first;
    assign upper_a = (fb_mode == 2'h1) ? s0_a : raw_upper;
    assign first_b = (fb_mode == 2'h2) ? s3_b : raw_first;
    assign upper_b = (fb_mode == 2'h1) ? s0_b : raw_upper;

    // Ten cycles each level: room for the input filter and one feedback hop
    task automatic pulse(input bit upper);
        @(negedge core_clk);
        if (upper) begin
            raw_upper = 1'h0;
        end else begin
            raw_first = 1'h0;
        end
        repeat (10) @(negedge core_clk);
        raw_upper = 1'h1;
        raw_first = 1'h1;
        repeat (10) @(negedge core_clk);
    endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for both counter variants
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst_b, preset_sel_n, clear_n;
    logic [3:0] data_in, q_a, q_b;
    logic [1:0] fb_mode;
    logic first_a, upper_a, first_b, upper_b;
    int mismatches = 0;
    int total_checks = 0;

    prc_counter #(.DECADE(1'b1)) i_dut (.core_clk, .rst_b, .first_count_in(first_a),
        .upper_section_count_in(upper_a), .preset_sel_n, .clear_n, .data_in,
        .stage0_output(q_a[0]), .stage1_output(q_a[1]), .stage2_output(q_a[2]),
        .stage3_output(q_a[3]));
    prc_counter #(.DECADE(1'b0)) i_bin (.core_clk, .rst_b, .first_count_in(first_b),
        .upper_section_count_in(upper_b), .preset_sel_n, .clear_n, .data_in,
        .stage0_output(q_b[0]), .stage1_output(q_b[1]), .stage2_output(q_b[2]),
        .stage3_output(q_b[3]));
    prc_src i_src (.core_clk, .fb_mode, .s0_a(q_a[0]), .s3_a(q_a[3]), .s0_b(q_b[0]),
        .s3_b(q_b[3]), .first_a, .upper_a, .first_b, .upper_b);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Controls held eight cycles, well past the filter latency
    task automatic ctl(input logic ps, input logic cl, input logic [3:0] d);
        @(negedge core_clk);
        preset_sel_n = ps;
        clear_n = cl;
        data_in = d;
        repeat (8) @(negedge core_clk);
    endtask

    task automatic stop_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_clear_load();
        ctl(1'h0, 1'h1, 4'hF);
        chk("load dec", 4'hF, q_a);
        chk("load bin", 4'hF, q_b);
        ctl(1'h0, 1'h0, 4'hF);
        chk("clear over load", 4'h0, q_a);
        ctl(1'h1, 1'h1, 4'hF);
        chk("hold after both", 4'h0, q_b);
        ctl(1'h0, 1'h1, 4'hA);
        ctl(1'h1, 1'h1, 4'hA);
        clear_n = 1'h0;
        i_src.pulse(1'b0);
        chk("clear with count", 4'h0, q_a | q_b);
        ctl(1'h1, 1'h1, 4'h0);
    endtask

    task automatic t_latch();
        ctl(1'h0, 1'h1, 4'h5);
        ctl(1'h0, 1'h1, 4'h3);
        chk("latch follows", 4'h3, q_a);
        ctl(1'h1, 1'h1, 4'h3);
        ctl(1'h1, 1'h1, 4'hC);
        chk("latch holds", 4'h3, q_a);
    endtask

    task automatic t_indep();
        fb_mode = 2'h0;
        ctl(1'h0, 1'h1, 4'h9);
        ctl(1'h1, 1'h1, 4'h9);
        i_src.pulse(1'b1);
        chk("quinary wrap", 4'h1, q_a);
        chk("octal step", 4'hB, q_b);
        i_src.pulse(1'b0);
        chk("stage0 alone", 4'h0, q_a);
        chk("stage0 alone bin", 4'hA, q_b);
    endtask

    task automatic t_chain(input logic [1:0] mode);
        ctl(1'h1, 1'h0, 4'h0);
        // Swap the wiring under clear so the swap gives no counted edge
        fb_mode = mode;
        ctl(1'h1, 1'h1, 4'h0);
        for (int k = 1; k <= 16; k++) begin
            i_src.pulse(mode == 2'h2);
            if (mode == 2'h1) begin
                chk("bcd", 4'(k % 10), q_a);
                chk("hex", 4'(k % 16), q_b);
            end else if (k <= 10) begin
                chk("biquinary", {3'(k % 5), 1'(k % 10 >= 5)}, q_a);
                chk("three bit", 4'(k % 8), {1'b0, q_b[3:1]});
            end
        end
    endtask

    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        rst_b = 1'h0;
        preset_sel_n = 1'h1;
        clear_n = 1'h1;
        data_in = 4'h0;
        fb_mode = 2'h0;
        repeat (4) @(negedge core_clk);
        rst_b = 1'h1;
        repeat (4) @(negedge core_clk);
        t_clear_load();
        t_latch();
        t_indep();
        t_chain(2'h1);
        t_chain(2'h2);
        stop_test();
    end

    // Whole run takes about 890 cycles; this is about eleven times that
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end
endmodule
